/* src/sfsp_status_ctrl.v */
`timescale 1ns/10ps
`include "sfsp_consts.vh"
module sfsp_status_ctrl (
    input  wire        clk,
    input  wire        reset,
    input  wire        chip_select_n,
    input  wire        sck,
    input  wire        si,
    input  wire        write_protect_n_in,
    input  wire        op_done,
    output reg         so,
    output wire        so_oe_n,
    output wire        io2_oe_n,
    output wire        io3_oe_n,
    output wire        quad_enable,
    output wire        status_write_disable,
    output wire        write_enable_latch,
    output wire        busy_flag,
    output wire        top_bottom_select,
    output wire [3:0]  protect_code,
    output reg         array_op_start,
    output reg  [7:0]  array_op_code,
    output reg  [23:0] array_op_addr,
    output wire [7:0]  status_and_protection
);
    // ==========================================================
    // state
    localparam ST_CMD  = 2'h0;
    localparam ST_ADDR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_READ = 2'h3;

    reg [1:0]                st_reg;
    reg [`SFSP_BITCNT_W-1:0] cnt_reg;
    reg [31:0]               sh_reg;
    reg [7:0]                op_reg;
    reg [7:0]                rd_byte_reg;
    reg [2:0]                rd_idx_reg;
    reg [5:0]                nv_reg;
    reg                      latch_reg;
    reg                      busy_reg;
    reg [`SFSP_BUSY_W-1:0]   busy_cnt_reg;
    reg                      bottom_sel_reg;
    reg                      sck_d_reg;
    reg                      cs_d_reg;
    reg                      wsr_pend_reg;
    reg [7:0]                wsr_data_reg;
    reg                      wfr_pend_reg;
    reg                      wfr_data_reg;

    wire rise  = sck & ~sck_d_reg;
    wire fall  = ~sck & sck_d_reg;
    wire desel = chip_select_n & ~cs_d_reg;
    wire [31:0] sh_in = {sh_reg[30:0], si};

    function is_guarded;
        input [7:0] op;
        begin
            case (op)
                `SFSP_OP_PROG_1, `SFSP_OP_PROG4_A, `SFSP_OP_PROG4_B, `SFSP_OP_ROW_PROG,
                `SFSP_OP_SECT_A, `SFSP_OP_SECT_B, `SFSP_OP_BE32, `SFSP_OP_BE64,
                `SFSP_OP_CE_A, `SFSP_OP_CE_B, `SFSP_OP_STAT_WRITE, `SFSP_OP_FUNC_WRITE,
                `SFSP_OP_ROW_ERASE: is_guarded = 1'b1;
                default:         is_guarded = 1'b0;
            endcase
        end
    endfunction

    function needs_addr;
        input [7:0] op;
        begin
            case (op)
                `SFSP_OP_PROG_1, `SFSP_OP_PROG4_A, `SFSP_OP_PROG4_B, `SFSP_OP_ROW_PROG,
                `SFSP_OP_SECT_A, `SFSP_OP_SECT_B, `SFSP_OP_BE32, `SFSP_OP_BE64,
                `SFSP_OP_ROW_ERASE: needs_addr = 1'b1;
                default:         needs_addr = 1'b0;
            endcase
        end
    endfunction

    function is_array_region;
        input [7:0] op;
        begin
            // info row is outside the block map
            is_array_region = needs_addr(op) && (op != `SFSP_OP_ROW_PROG)
                              && (op != `SFSP_OP_ROW_ERASE);
        end
    endfunction

    assign protect_code         = nv_reg[`SFSP_BP_HI-2:0];
    assign quad_enable          = nv_reg[`SFSP_BIT_QUAD-2];
    assign status_write_disable = nv_reg[`SFSP_BIT_LOCK-2];
    assign write_enable_latch   = latch_reg;
    assign busy_flag            = busy_reg;
    assign top_bottom_select    = bottom_sel_reg;
    assign status_and_protection = {nv_reg, latch_reg, busy_reg};

    // protect/hold become data lines; inputs only here
    assign io2_oe_n = 1'b1;
    assign io3_oe_n = 1'b1;
    assign so_oe_n  = ~((st_reg == ST_READ) & ~chip_select_n);

    wire hw_lock = status_write_disable & ~write_protect_n_in & ~quad_enable;

    wire       addr_prot;
    sfsp_prot_decode u_prot (
        .protect_code      (protect_code),
        .top_bottom_select (bottom_sel_reg),
        .block_index       (sh_in[`SFSP_ADDR_BLK_HI:`SFSP_ADDR_BLK_LO]),
        .block_protected   (addr_prot)
    );

    // ==========================================================
    // serial front end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sck_d_reg    <= 1'b0;
            cs_d_reg     <= 1'b1;
            st_reg       <= ST_CMD;
            cnt_reg      <= {`SFSP_BITCNT_W{1'b0}};
            sh_reg       <= 32'h0000_0000;
            op_reg       <= 8'h00;
            rd_byte_reg  <= 8'h00;
            rd_idx_reg   <= 3'h7;
            so           <= 1'b0;
            wsr_pend_reg <= 1'b0;
            wsr_data_reg <= 8'h00;
            wfr_pend_reg <= 1'b0;
            wfr_data_reg <= 1'b0;
            array_op_start <= 1'b0;
            array_op_code  <= 8'h00;
            array_op_addr  <= 24'h00_0000;
        end else begin
            sck_d_reg      <= sck;
            cs_d_reg       <= chip_select_n;
            array_op_start <= 1'b0;
            wsr_pend_reg   <= 1'b0;
            wfr_pend_reg   <= 1'b0;
            if (chip_select_n) begin
                st_reg  <= ST_CMD;
                cnt_reg <= {`SFSP_BITCNT_W{1'b0}};
            end else if (rise) begin
                sh_reg  <= sh_in;
                cnt_reg <= cnt_reg + 1'b1;
                case (st_reg)
                    ST_CMD: begin
                        if (cnt_reg + 1'b1 == `SFSP_CMD_BITS) begin
                            op_reg <= sh_in[7:0];
                            if (sh_in[7:0] == `SFSP_OP_STAT_READ ||
                                sh_in[7:0] == `SFSP_OP_RDFR_R) begin
                                st_reg      <= ST_READ;
                                rd_byte_reg <= (sh_in[7:0] == `SFSP_OP_STAT_READ) ?
                                               status_and_protection :
                                               {6'h00, bottom_sel_reg, 1'b0};
                                rd_idx_reg  <= 3'h7;
                            end else if (needs_addr(sh_in[7:0])) begin
                                st_reg <= ST_ADDR;
                            end else begin
                                st_reg <= ST_DATA;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (cnt_reg + 1'b1 == `SFSP_ADDR_BITS) begin
                            st_reg        <= ST_DATA;
                            array_op_code <= op_reg;
                            array_op_addr <= sh_in[23:0];
                            array_op_start <= ~busy_reg & latch_reg &
                                ~(is_array_region(op_reg) & addr_prot);
                        end
                    end
                    ST_DATA: begin
                        if (cnt_reg + 1'b1 == `SFSP_DATA1_BITS) begin
                            if (op_reg == `SFSP_OP_STAT_WRITE) begin
                                wsr_data_reg <= sh_in[7:0];
                            end
                            if (op_reg == `SFSP_OP_FUNC_WRITE) begin
                                wfr_data_reg <= sh_in[`SFSP_FN_BOTTOM];
                            end
                        end
                    end
                    ST_READ: begin
                        st_reg <= ST_READ;
                    end
                    default: st_reg <= ST_CMD;
                endcase
            end else if (fall && st_reg == ST_READ) begin
                // drive on falling edge, byte repeats
                so         <= rd_byte_reg[rd_idx_reg];
                rd_idx_reg <= rd_idx_reg - 3'h1;
            end
            // commit register writes on deselect
            if (desel && op_reg == `SFSP_OP_STAT_WRITE && cnt_reg >= `SFSP_DATA1_BITS) begin
                wsr_pend_reg <= 1'b1;
            end
            if (desel && op_reg == `SFSP_OP_FUNC_WRITE && cnt_reg >= `SFSP_DATA1_BITS) begin
                wfr_pend_reg <= 1'b1;
            end
            if (desel && (op_reg == `SFSP_OP_CE_A || op_reg == `SFSP_OP_CE_B) &&
                cnt_reg == `SFSP_CMD_BITS) begin
                array_op_code <= op_reg;
                array_op_addr <= 24'h00_0000;
                array_op_start <= ~busy_reg & latch_reg & (protect_code == 4'h0);
            end
        end
    end

    // ==========================================================
    // status register, latch, busy
    wire wsr_ok = wsr_pend_reg & ~busy_reg & latch_reg & ~hw_lock;
    wire wfr_ok = wfr_pend_reg & ~busy_reg & latch_reg;
    wire cmd_end = desel & (cnt_reg == `SFSP_CMD_BITS);

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            // persistent bits start at shipped value
            nv_reg       <= `SFSP_NV_RESET;
            latch_reg      <= 1'b0;
            busy_reg       <= 1'b0;
            busy_cnt_reg   <= {`SFSP_BUSY_W{1'b0}};
            bottom_sel_reg <= 1'b0;
        end else begin
            // only status write updates bits 7..2
            if (wsr_ok) begin
                nv_reg <= wsr_data_reg[`SFSP_BIT_LOCK:`SFSP_BP_LO];
            end
            if (wfr_ok && wfr_data_reg) begin
                bottom_sel_reg <= 1'b1;
            end
            if (wsr_ok | wfr_ok) begin
                busy_reg     <= 1'b1;
                busy_cnt_reg <= `SFSP_BUSY_CYC;
            end else if (array_op_start) begin
                busy_reg <= 1'b1;
            end else if (busy_reg && busy_cnt_reg != {`SFSP_BUSY_W{1'b0}}) begin
                busy_cnt_reg <= busy_cnt_reg - 1'b1;
                if (busy_cnt_reg == 16'h0001) begin
                    busy_reg <= 1'b0;
                end
            end else if (busy_reg && op_done) begin
                busy_reg <= 1'b0;
            end
            // latch set/clear; ends of writes clear it
            if (cmd_end && op_reg == `SFSP_OP_WR_ENABLE && !busy_reg) begin
                latch_reg <= 1'b1;
            end else if (cmd_end && op_reg == `SFSP_OP_WR_DISABLE && !busy_reg) begin
                latch_reg <= 1'b0;
            end else if (busy_reg && !(wsr_ok | wfr_ok | array_op_start) &&
                         ((busy_cnt_reg == 16'h0001) ||
                          (busy_cnt_reg == {`SFSP_BUSY_W{1'b0}} && op_done))) begin
                latch_reg <= 1'b0;
            end
        end
    end
endmodule

/* src/sfsp_consts.vh */
`ifndef SFSP_CONSTS_VH
`define SFSP_CONSTS_VH

// ==========================================================
// opcodes
`define SFSP_OP_WR_ENABLE  8'h06
`define SFSP_OP_WR_DISABLE 8'h04
`define SFSP_OP_STAT_READ  8'h05
`define SFSP_OP_RDFR_R   8'h48
`define SFSP_OP_STAT_WRITE 8'h01
`define SFSP_OP_FUNC_WRITE 8'h42
`define SFSP_OP_PROG_1   8'h02
`define SFSP_OP_PROG4_A  8'h32
`define SFSP_OP_PROG4_B  8'h38
`define SFSP_OP_ROW_PROG 8'h62
`define SFSP_OP_SECT_A   8'hD7
`define SFSP_OP_SECT_B   8'h20
`define SFSP_OP_BE32     8'h52
`define SFSP_OP_BE64     8'hD8
`define SFSP_OP_CE_A     8'hC7
`define SFSP_OP_CE_B     8'h60
`define SFSP_OP_ROW_ERASE 8'h64

// ==========================================================
// status fields
`define SFSP_BIT_BUSY    0
`define SFSP_BIT_LATCH   1
`define SFSP_BP_LO       2
`define SFSP_BP_HI       5
`define SFSP_BIT_QUAD    6
`define SFSP_BIT_LOCK    7
`define SFSP_FN_BOTTOM   1
`define SFSP_NV_RESET    6'h00
`define SFSP_ADDR_BLK_HI 22
`define SFSP_ADDR_BLK_LO 16

// ==========================================================
// timing and widths
`define SFSP_BITCNT_W    6
`define SFSP_CMD_BITS    6'h08
`define SFSP_ADDR_BITS   6'h20
`define SFSP_DATA1_BITS  6'h10
`define SFSP_BUSY_W      16
`define SFSP_BUSY_CYC    16'h0040

`endif

/* src/sfsp_prot_decode.v */
`timescale 1ns/10ps
`include "sfsp_consts.vh"
module sfsp_prot_decode (
    input  wire [3:0] protect_code,
    input  wire       top_bottom_select,
    input  wire [6:0] block_index,
    output reg        block_protected
);
    reg [7:0] span;
    always @* begin
        span = 8'h00;
        case (protect_code[2:0])
            3'h0:    span = 8'h00;
            3'h1:    span = 8'h01;
            3'h2:    span = 8'h02;
            3'h3:    span = 8'h04;
            3'h4:    span = 8'h08;
            3'h5:    span = 8'h10;
            3'h6:    span = 8'h20;
            3'h7:    span = 8'h40;
            default: span = 8'h00;
        endcase
        if (protect_code[3]) begin
            block_protected = 1'b1;
        end else if (top_bottom_select) begin
            block_protected = ({1'b0, block_index} < span);
        end else begin
            block_protected = ({1'b0, block_index} >= (8'h80 - span));
        end
    end
endmodule

/* tb/sfsp_checker.sv */
`timescale 1ns/10ps
// ==========================================
// status block checker
module sfsp_checker (
    input logic        clk,
    input logic        reset,
    input logic        chip_select_n,
    input logic        write_protect_n_in,
    input logic        quad_enable,
    input logic        status_write_disable,
    input logic        write_enable_latch,
    input logic        busy_flag,
    input logic        top_bottom_select,
    input logic [3:0]  protect_code,
    input logic        array_op_start,
    input logic [7:0]  array_op_code,
    input logic [23:0] array_op_addr,
    input logic [7:0]  status_and_protection
);
    logic [15:0] busy_cnt_reg;
    logic        arr_op_reg;
    logic        erase_all;
    logic        no_region;
    logic [7:0]  blk;
    logic [7:0]  span;
    logic        hit;
    logic        in_region;

    assign erase_all = array_op_code == 8'hC7 || array_op_code == 8'h60;
    assign no_region = erase_all || array_op_code == 8'h62 || array_op_code == 8'h64;
    // code n covers 2^(n-1) blocks, bit 3 covers all
    assign blk       = {1'b0, array_op_addr[22:16]};
    assign span      = 8'h01 << (protect_code - 4'h1);
    assign hit       = top_bottom_select ? blk < span : blk >= 8'h80 - span;
    assign in_region = protect_code[3] || (protect_code != 4'h0 && hit);

    // array flag kept until busy has been seen and fallen
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_cnt_reg <= 16'h0000;
            arr_op_reg   <= 1'b0;
        end
        else begin
            busy_cnt_reg <= busy_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
            arr_op_reg   <= array_op_start | (arr_op_reg & (busy_flag | busy_cnt_reg == 16'h0000));
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    latch_needed_a: assert property (array_op_start |-> write_enable_latch)
        else $error("op started without latch");
    idle_needed_a: assert property (array_op_start |-> !$past(busy_flag))
        else $error("op started while busy");
    chip_erase_a: assert property (array_op_start && erase_all |-> protect_code == 4'h0)
        else $error("chip erase with nonzero code");
    prot_region_a: assert property (array_op_start && !no_region |-> !in_region)
        else $error("op started in protected block");
    lock_hold_a: assert property (status_write_disable && !write_protect_n_in && !quad_enable
        |=> $stable(status_and_protection[7:2])) else $error("locked bits changed");
    latch_deselect_a: assert property ($rose(write_enable_latch) |-> chip_select_n)
        else $error("latch set inside a frame");
    latch_clear_a: assert property ($fell(busy_flag) |-> !write_enable_latch)
        else $error("latch kept after write");
    busy_len_a: assert property ($fell(busy_flag) && !arr_op_reg |-> busy_cnt_reg == 16'h0040)
        else $error("register write busy length wrong");
endmodule

bind sfsp_status_ctrl sfsp_checker u_chk (.clk, .reset, .chip_select_n, .write_protect_n_in,
    .quad_enable, .status_write_disable, .write_enable_latch, .busy_flag, .top_bottom_select,
    .protect_code, .array_op_start, .array_op_code, .array_op_addr, .status_and_protection);

/* tb/sfsp_host_model.sv */
`timescale 1ns/10ps
// ==========================================
// spi host, mode 0, clock idles low
module sfsp_host_model (
    input  wire  clk,
    input  wire  so,
    output logic chip_select_n,
    output logic sck,
    output logic si
);
    initial begin
        chip_select_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // drive after fall, sample before rise
    task automatic put_bit(input logic b, output logic q);
        @(posedge clk) sck <= 1'b0;
        si <= b;
        repeat (4) @(posedge clk);
        q = so;
        sck <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                        input int na, input int nd, output logic [7:0] r1,
                        output logic [7:0] r2);
        logic [31:0] w;
        logic        q;
        w = {op, a};
        r2 = 8'h00;
        @(posedge clk) chip_select_n <= 1'b0;
        for (int i = 0; i < 8 + 24 * na; i++)
            put_bit(w[31 - i], q);
        for (int i = 0; i < 8 * nd; i++) begin
            put_bit(d[7 - i % 8], q);
            r2 = {r2[6:0], q};
            if (i == 7)
                r1 = r2;
        end
        @(posedge clk) sck <= 1'b0;
        repeat (2) @(posedge clk);
        chip_select_n <= 1'b1;
        // released line must not keep its last level
        si <= ~si;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
// ==========================================
// status and protection bench
module tb_top;
    logic        clk, reset, chip_select_n, sck, si, so;
    logic        write_protect_n_in, op_done, array_op_start;
    logic [7:0]  array_op_code, r1, r2, lfsr, s, n;
    logic [23:0] array_op_addr;
    logic [31:0] e;
    logic [31:0] exp_q[$];
    logic [7:0]  ops[11] = '{8'h02, 8'h32, 8'h38, 8'h62, 8'hD7, 8'h20, 8'h52, 8'hD8,
                             8'h64, 8'hC7, 8'h60};
    int          err_count, check_count;

    sfsp_status_ctrl dut (.clk, .reset, .chip_select_n, .sck, .si, .write_protect_n_in,
        .op_done, .so, .so_oe_n(), .io2_oe_n(), .io3_oe_n(), .quad_enable(),
        .status_write_disable(), .write_enable_latch(), .busy_flag(), .top_bottom_select(),
        .protect_code(), .array_op_start, .array_op_code, .array_op_addr,
        .status_and_protection());
    sfsp_host_model host (.clk, .so, .chip_select_n, .sck, .si);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
        check_count++;
        if (y !== x) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, x, y);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
                       input int na, input int nd);
        host.xfer(op, a, d, na, nd, r1, r2);
    endtask

    task automatic rd(input logic [7:0] x);
        cmd(8'h05, 24'h0, 8'h00, 0, 2);
        chk("status", {24'h0, x}, {24'h0, r1});
        chk("status repeat", {24'h0, x}, {24'h0, r2});
    endtask

    task automatic idle();
        int k;
        k = 0;
        r1 = 8'h01;
        while (r1[0] !== 1'b0) begin
            if (k == 40) begin
                err_count++;
                print_verdict();
            end
            cmd(8'h05, 24'h0, 8'h00, 0, 1);
            k++;
        end
    endtask

    task automatic wsr(input logic [7:0] op, input logic [7:0] v);
        cmd(8'h06, 24'h0, 8'h00, 0, 0);
        cmd(op, 24'h0, v, 0, 1);
        idle();
    endtask

    task automatic try(input logic [7:0] op, input logic [7:0] k, input logic ok,
                       input logic [7:0] st);
        logic [23:0] a;
        int          na;
        a = {rnd(), rnd(), rnd()};
        a[22:16] = k[6:0];
        na = (op == 8'hC7 || op == 8'h60) ? 0 : 1;
        // chip erase reports a zero address
        if (na == 0)
            a = 24'h00_0000;
        cmd(8'h06, 24'h0, 8'h00, 0, 0);
        if (ok)
            exp_q.push_back({op, a});
        cmd(op, a, 8'h00, na, 0);
        if (ok) begin
            rd(st | 8'h03);
            cmd(op, a, 8'h00, na, 0);
            @(posedge clk) op_done <= 1'b1;
            @(posedge clk) op_done <= 1'b0;
        end
        else begin
            rd(st | 8'h02);
            cmd(8'h04, 24'h0, 8'h00, 0, 0);
        end
        rd(st);
    endtask

    // each accepted op pairs with the oldest note
    always @(posedge clk) begin
        if (array_op_start) begin
            e = exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF;
            chk("array op", e, {array_op_code, array_op_addr});
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    initial begin
        lfsr = 8'h27;
        reset = 1'b1;
        write_protect_n_in = 1'b1;
        op_done = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h00);
        cmd(8'h02, 24'h010000, 8'h00, 1, 0);
        cmd(8'h01, 24'h0, 8'h0C, 0, 1);
        rd(8'h00);
        foreach (ops[i])
            try(ops[i], rnd(), 1'b1, 8'h00);
        for (int t = 0; t < 2; t++) begin
            if (t == 1) begin
                wsr(8'h42, 8'h02);
                wsr(8'h42, 8'h00);
            end
            for (int c = 1; c < 9; c++) begin
                n = 8'(1 << (c - 1));
                s = 8'(c * 4);
                wsr(8'h01, s);
                try(8'hD8, t ? n - 8'h01 : 8'h80 - n, 1'b0, s);
                if (c < 8)
                    try(8'h20, t ? n : 8'h7F - n, 1'b1, s);
            end
            try(8'hC7, 8'h00, 1'b0, s);
        end
        wsr(8'h01, 8'h80);
        write_protect_n_in <= 1'b0;
        wsr(8'h01, 8'h04);
        rd(8'h82);
        write_protect_n_in <= 1'b1;
        // pins are free in this bench, quad enable allowed
        wsr(8'h01, 8'h40);
        rd(8'h40);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h00);
        chk("pending notes", 32'h0, 32'(exp_q.size()));
        print_verdict();
    end
endmodule
